// *** hdl/comp_pwm_pkg.sv ***
// shared constants and types for the complementary pwm output stage
package comp_pwm_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] AUX_CONTROL_IDX = 12'h110;
    localparam logic [11:0] MAIN_CTRL_IDX   = 12'h111;
    localparam logic [11:0] TICK_CTRL_IDX   = 12'h112;
    localparam logic [11:0] PHASE_ONE_IDX   = 12'h113;
    localparam logic [11:0] PHASE_TWO_IDX   = 12'h114;
    localparam logic [11:0] STATUS_IDX      = 12'h115;
    localparam logic [11:0] AUX_CONTROL_ADDR = 12'h440;
    localparam logic [11:0] MAIN_CTRL_ADDR   = 12'h444;
    localparam logic [11:0] TICK_CTRL_ADDR   = 12'h448;
    localparam logic [11:0] PHASE_ONE_ADDR   = 12'h44c;
    localparam logic [11:0] PHASE_TWO_ADDR   = 12'h450;
    localparam logic [11:0] STATUS_ADDR      = 12'h454;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // main control field positions
    localparam int PHASE_ONE_EN_BIT = 0;
    localparam int PHASE_TWO_EN_BIT = 1;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // dead band timing
    localparam int DEAD_STEP_NS  = 5;
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEAD_CNT_W    = 2;

    // phase control register layout
    typedef struct packed {
        logic       outputInvert;
        logic       compTwoTermEnable;
        logic       compOneTermEnable;
        logic [4:0] phaseCount;
    } phaseCtrl_t;

    // auxiliary control register layout; top bit always zero
    typedef struct packed {
        logic       unused;
        logic [1:0] compModeSelect;
        logic [4:0] deadTimeSelect;
    } auxCtrl_t;

    // complementary mode select encodings, in field order
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_COMPARATOR,
        MODE_COUNTER,
        MODE_BOTH
    } compMode_t;

    // first-cycle tracking after shutdown or reset
    typedef enum logic {
        ST_STARTUP,
        ST_RUN
    } phaseState_t;

endpackage

// *** hdl/dead_band_delay.sv ***
// delays the turn-on edge of one drive request by a cycle count
module dead_band_delay
    import comp_pwm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  req,        // wanted active level
    input  wire logic [DEAD_CNT_W-1:0] deadCycles, // turn-on delay
    output logic                       drive       // delayed active level
);

    logic [DEAD_CNT_W-1:0] wait_r; // cycles still to wait before turn-on

    // turn-off passes at once, turn-on waits out the dead time
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_r <= '0;
            drive  <= 1'b0;
        end else if (!req) begin
            // reload so every turn-on starts a fresh wait
            wait_r <= deadCycles;
            drive  <= 1'b0;
        end else if (wait_r != '0) begin
            wait_r <= wait_r - 1'b1;
        end else begin
            drive <= 1'b1;
        end
    end

endmodule

// *** hdl/comp_pwm_output.sv ***
// complementary pwm output stage with axi4-lite register access
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module comp_pwm_output
    import comp_pwm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    // axi4-lite slave
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // pwm side
    input  wire logic [4:0]  pwmCount,           // free-running phase count
    input  wire logic        comparatorOneOut,   // comparator one result
    input  wire logic        comparatorTwoOut,   // comparator two result
    input  wire logic        shutdown,           // shutdown request, high
    output logic             phaseOneOut,        // phase one gate drive
    output logic             phaseTwoOut         // phase two gate drive
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    auxCtrl_t    auxCtrl_r;   // mode and dead time select
    logic [7:0]  mainCtrl_r;  // phase enables and system options
    logic [7:0]  tickCtrl_r;  // held for software, counter lives outside
    phaseCtrl_t  phaseOne_r;  // phase one start and terminations
    phaseCtrl_t  phaseTwo_r;  // phase two count and terminations

    logic        activeOne_r; // phase one interval in progress
    logic        activeTwo_r; // phase two interval, normal mode only
    phaseState_t state_r;     // first cycle after shutdown

    compMode_t   mode;        // decoded complementary mode
    logic        compOn;      // any complementary mode
    logic        startOne;    // phase one start match
    logic        startTwo;    // phase two start match, normal mode
    logic        cmpEndOne;   // enabled comparator ended phase one
    logic        cmpEndTwo;   // enabled comparator ended phase two
    logic        cntEnd;      // phase-two count match
    logic        endOne;      // phase one interval ends this cycle
    logic        reqOne;      // phase one drive request before dead band
    logic        reqTwo;      // phase two drive request before dead band
    logic        driveOne;    // phase one after dead band
    logic        driveTwo;    // phase two after dead band
    logic [7:0]  deadSum;     // rounding sum for the dead count
    logic [DEAD_CNT_W-1:0] deadCycles; // dead time in clock cycles

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic        wrGo;        // address and data taken together
    logic        rdGo;        // read address taken
    logic        wrHit;       // write address decodes to a register
    logic [7:0]  rdValue;     // read mux result
    logic        rdHit;       // read address decodes to a register

    assign wrGo = awvalid && wvalid && !awready && !bvalid;
    assign rdGo = arvalid && !arready && !rvalid;

    // write address decode
    always_comb begin
        wrHit = 1'b1;
        if (awaddr == AUX_CONTROL_ADDR) begin
            wrHit = 1'b1;
        end else if (awaddr == MAIN_CTRL_ADDR) begin
            wrHit = 1'b1;
        end else if (awaddr == TICK_CTRL_ADDR) begin
            wrHit = 1'b1;
        end else if (awaddr == PHASE_ONE_ADDR) begin
            wrHit = 1'b1;
        end else if (awaddr == PHASE_TWO_ADDR) begin
            wrHit = 1'b1;
        end else if (awaddr == STATUS_ADDR) begin
            // status is read only, writes are ignored but answered
            wrHit = 1'b1;
        end else begin
            wrHit = 1'b0;
        end
    end

    // read address decode and data mux
    always_comb begin
        rdHit   = 1'b1;
        rdValue = 8'h00;
        if (araddr == AUX_CONTROL_ADDR) begin
            rdValue = {1'b0, auxCtrl_r[6:0]};
        end else if (araddr == MAIN_CTRL_ADDR) begin
            rdValue = mainCtrl_r;
        end else if (araddr == TICK_CTRL_ADDR) begin
            rdValue = tickCtrl_r;
        end else if (araddr == PHASE_ONE_ADDR) begin
            rdValue = phaseOne_r;
        end else if (araddr == PHASE_TWO_ADDR) begin
            rdValue = phaseTwo_r;
        end else if (araddr == STATUS_ADDR) begin
            rdValue = {4'h0, phaseTwoOut, phaseOneOut,
                       state_r == ST_STARTUP, activeOne_r};
        end else begin
            rdHit = 1'b0;
        end
    end

    // write channel handshake and response
    always_ff @(posedge clk) begin
        if (!nrst) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            awready <= wrGo;
            wready  <= wrGo;
            if (wrGo) begin
                bvalid <= 1'b1;
                bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // register writes; only the low byte lane carries data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            auxCtrl_r  <= auxCtrl_t'(REG_RESET);
            mainCtrl_r <= REG_RESET;
            tickCtrl_r <= REG_RESET;
            phaseOne_r <= phaseCtrl_t'(REG_RESET);
            phaseTwo_r <= phaseCtrl_t'(REG_RESET);
        end else if (wrGo && wstrb[0]) begin
            if (awaddr == AUX_CONTROL_ADDR) begin
                // top bit is not stored, so it can never read back as one
                auxCtrl_r <= auxCtrl_t'({1'b0, wdata[6:0]});
            end else if (awaddr == MAIN_CTRL_ADDR) begin
                mainCtrl_r <= wdata[7:0];
            end else if (awaddr == TICK_CTRL_ADDR) begin
                tickCtrl_r <= wdata[7:0];
            end else if (awaddr == PHASE_ONE_ADDR) begin
                phaseOne_r <= phaseCtrl_t'(wdata[7:0]);
            end else if (awaddr == PHASE_TWO_ADDR) begin
                phaseTwo_r <= phaseCtrl_t'(wdata[7:0]);
            end
        end
    end

    // read channel handshake and data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= rdGo;
            if (rdGo) begin
                rvalid <= 1'b1;
                rdata  <= {24'h00_0000, rdValue};
                rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // duty cycle start and termination

    assign mode      = compMode_t'(auxCtrl_r.compModeSelect);
    assign compOn    = (mode != MODE_NORMAL);
    assign startOne  = (pwmCount == phaseOne_r.phaseCount);
    assign startTwo  = (pwmCount == phaseTwo_r.phaseCount);
    assign cntEnd    = startTwo;
    assign cmpEndOne = (phaseOne_r.compOneTermEnable && comparatorOneOut) ||
                       (phaseOne_r.compTwoTermEnable && comparatorTwoOut);
    assign cmpEndTwo = (phaseTwo_r.compOneTermEnable && comparatorOneOut) ||
                       (phaseTwo_r.compTwoTermEnable && comparatorTwoOut);

    // termination source chosen by mode
    always_comb begin
        case (mode)
            MODE_COMPARATOR: endOne = cmpEndOne;
            MODE_COUNTER:    endOne = cntEnd;
            MODE_BOTH:       endOne = cntEnd || cmpEndOne;
            default:         endOne = cmpEndOne;
        endcase
    end

    // phase one interval; a termination in the start cycle wins, so a
    // comparator already high holds the output off for the whole period
    always_ff @(posedge clk) begin
        if (!nrst) begin
            activeOne_r <= 1'b0;
        end else if (shutdown || !mainCtrl_r[PHASE_ONE_EN_BIT]) begin
            activeOne_r <= 1'b0;
        end else if (endOne) begin
            activeOne_r <= 1'b0;
        end else if (startOne) begin
            activeOne_r <= 1'b1;
        end
    end

    // phase two interval, used only in normal two-phase operation
    always_ff @(posedge clk) begin
        if (!nrst) begin
            activeTwo_r <= 1'b0;
        end else if (shutdown || compOn ||
                     !mainCtrl_r[PHASE_TWO_EN_BIT]) begin
            activeTwo_r <= 1'b0;
        end else if (cmpEndTwo) begin
            activeTwo_r <= 1'b0;
        end else if (startTwo) begin
            activeTwo_r <= 1'b1;
        end
    end

    // start-up tracking: held until the first duty start after shutdown
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_STARTUP;
        end else begin
            case (state_r)
                ST_STARTUP: begin
                    if (!shutdown && startOne) begin
                        state_r <= ST_RUN;
                    end
                end
                default: begin
                    if (shutdown) begin
                        state_r <= ST_STARTUP;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drive requests, dead band and polarity

    // complementary pair follows one interval; during the start-up
    // state phase one is still off, so phase two drives
    always_comb begin
        if (shutdown) begin
            reqOne = 1'b0;
            reqTwo = 1'b0;
        end else if (compOn) begin
            reqOne = activeOne_r;
            reqTwo = !activeOne_r && mainCtrl_r[PHASE_ONE_EN_BIT];
        end else begin
            reqOne = activeOne_r;
            reqTwo = activeTwo_r;
        end
    end

    // round the dead time up to whole clocks; normal mode has none
    assign deadSum = 8'(auxCtrl_r.deadTimeSelect) * 8'(DEAD_STEP_NS) +
                     8'(CLK_PERIOD_NS - 1);
    assign deadCycles = compOn ? DEAD_CNT_W'(deadSum / 8'(CLK_PERIOD_NS))
                               : '0;

    dead_band_delay u_delayOne (
        .clk        (clk),
        .nrst       (nrst),
        .req        (reqOne),
        .deadCycles (deadCycles),
        .drive      (driveOne)
    );

    dead_band_delay u_delayTwo (
        .clk        (clk),
        .nrst       (nrst),
        .req        (reqTwo),
        .deadCycles (deadCycles),
        .drive      (driveTwo)
    );

    // polarity applied last so the inactive level is the inverted one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phaseOneOut <= 1'b0;
            phaseTwoOut <= 1'b0;
        end else begin
            phaseOneOut <= driveOne ^ phaseOne_r.outputInvert;
            phaseTwoOut <= driveTwo ^ phaseTwo_r.outputInvert;
        end
    end

endmodule

// *** testbench/comp_pwm_partner.sv ***
// far-side model: free-running phase counter and two ramp comparators
module comp_pwm_partner (
    input  logic       clk,
    input  logic       nrst,
    input  logic [4:0] tripOne,  // comparator one threshold count
    input  logic [4:0] tripTwo,  // comparator two threshold count
    output logic [4:0] pwmCount, // phase count, wraps at 32
    output logic       cmpOne,   // comparator one result
    output logic       cmpTwo    // comparator two result
);
    timeunit 1ns;
    timeprecision 1ns;
    // counter restarts the ramp each period
    always_ff @(posedge clk) begin
        if (!nrst) pwmCount <= 5'h00;
        else pwmCount <= pwmCount + 5'h01;
    end
    // ramp stays above threshold until the wrap, as a real comparator
    assign cmpOne = pwmCount >= tripOne;
    assign cmpTwo = pwmCount >= tripTwo;
endmodule

// *** testbench/comp_pwm_output_monitor.sv ***
// assertion checker for the complementary pwm output stage
module comp_pwm_output_monitor
    import comp_pwm_pkg::*;
(
    input logic        clk,
    input logic        nrst,
    input logic [11:0] awaddr,
    input logic        awvalid,
    input logic        awready,
    input logic [31:0] wdata,
    input logic [3:0]  wstrb,
    input logic        wvalid,
    input logic        wready,
    input logic        bvalid,
    input logic        bready,
    input logic        arvalid,
    input logic        arready,
    input logic [31:0] rdata,
    input logic        rvalid,
    input logic        rready,
    input logic        shutdown,
    input logic        phaseOneOut,
    input logic        phaseTwoOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] compMode_r; // shadow of the mode field
    logic       invOne_r;   // shadow of the phase one output invert
    logic       invTwo_r;   // shadow of the phase two output invert
    logic       wrTake;     // low byte lane write handshake
    assign wrTake = awvalid && awready && wstrb[0];
    // shadows follow accepted writes, so exclusion is only checked in
    // complementary modes, and on drive levels before the inversion,
    // since inverted outputs both sit high in the dead band
    always_ff @(posedge clk) begin
        if (!nrst) begin
            compMode_r <= 2'h0;
            invOne_r   <= 1'b0;
            invTwo_r   <= 1'b0;
        end else if (wrTake) begin
            if (awaddr == AUX_CONTROL_ADDR) compMode_r <= wdata[6:5];
            if (awaddr == PHASE_ONE_ADDR) invOne_r <= wdata[7];
            if (awaddr == PHASE_TWO_ADDR) invTwo_r <= wdata[7];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    property p_wr;
        awvalid && wvalid && !awready && !bvalid |=> awready && wready && bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write not taken");
    property p_rd;
        arvalid && !arready && !rvalid |=> arready && rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read not taken");
    property p_awpulse;
        awready |=> !awready;
    endproperty
    a_awpulse: assert property (p_awpulse) else $error("awready held");
    property p_bhold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_rtop;
        rvalid |-> rdata[31:8] == 24'h000000;
    endproperty
    a_rtop: assert property (p_rtop) else $error("upper read bits set");
    property p_excl;
        compMode_r != 2'h0 |->
            !((phaseOneOut ^ invOne_r) && (phaseTwoOut ^ invTwo_r));
    endproperty
    a_excl: assert property (p_excl) else $error("both phases active");
    property p_sd;
        shutdown [*5] |->
            phaseOneOut == invOne_r && phaseTwoOut == invTwo_r;
    endproperty
    a_sd: assert property (p_sd) else $error("output during shutdown");
endmodule
bind comp_pwm_output comp_pwm_output_monitor mon (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .shutdown(shutdown), .phaseOneOut(phaseOneOut),
    .phaseTwoOut(phaseTwoOut)
);

// *** testbench/test_comp_pwm_output.sv ***
// self-checking bench for the complementary pwm output stage
module test_comp_pwm_output
    import comp_pwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, nrst = 1'b0, shutdown = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, p1, p2, c1, c2;
    logic [1:0]  bresp, rresp, rsp;
    logic [4:0]  cnt, trip1 = 5'h1f, trip2 = 5'h1f;
    int          n_mismatch = 0, cmp_count = 0, n1, n2;
    int          sel[5] = '{0, 1, 20, 21, 31}; // dead select values
    int          dl[5] = '{0, 1, 1, 2, 2};     // turn-on delay in cycles
    comp_pwm_output DUT (.clk(clk), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pwmCount(cnt), .comparatorOneOut(c1),
        .comparatorTwoOut(c2), .shutdown(shutdown), .phaseOneOut(p1),
        .phaseTwoOut(p2));
    comp_pwm_partner far (.clk(clk), .nrst(nrst), .tripOne(trip1),
        .tripTwo(trip2), .pwmCount(cnt), .cmpOne(c1), .cmpTwo(c2));
    ////////////////////////////////////////////////////////////////////////
    initial forever #50 clk = ~clk;
    // axi4-lite write; address and data offered together; a lag holds
    // bready back so the response must stand until it is taken
    task automatic axw(input logic [11:0] a, input logic [7:0] d,
                       input int lag = 0);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= (lag == 0);
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        if (lag > 0) begin
            repeat (lag) @(posedge clk);
            bready <= 1'b1;
            @(posedge clk);
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rsp = bresp; bready <= 1'b0;
        @(posedge clk);
    endtask
    // axi4-lite read; rready held until rvalid seen; a lag holds rready
    // back so read data must stand until it is taken
    task automatic axr(input logic [11:0] a, input int lag = 0);
        araddr <= a; arvalid <= 1'b1; rready <= (lag == 0);
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        if (lag > 0) begin
            repeat (lag) @(posedge clk);
            rready <= 1'b1;
            @(posedge clk);
        end
        while (rvalid !== 1'b1) @(posedge clk);
        rd = rdata; rsp = rresp; rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chkResp(input string s, input logic [1:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // settle, then count active cycles over exactly two 32-count periods
    task automatic meas(input int e1, e2);
        n1 = 0; n2 = 0;
        repeat (40) @(posedge clk);
        repeat (64) begin
            @(posedge clk);
            n1 += (p1 === 1'b1);
            n2 += (p2 === 1'b1);
        end
        chk("phaseOneOut active cycles", e1, n1);
        chk("phaseTwoOut active cycles", e2, n2);
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axr(AUX_CONTROL_ADDR);
        chk("aux reset value", 32'h0, rd);
        axw(AUX_CONTROL_ADDR, 8'hff, 3);
        axr(AUX_CONTROL_ADDR, 3);
        chk("aux readback", 32'h7f, rd);
        axr(12'h600);
        chkResp("unmapped read", RESP_SLVERR, rsp);
        axw(12'h600, 8'h11);
        chkResp("unmapped write", RESP_SLVERR, rsp);
        // counter mode; main control written last
        axw(PHASE_ONE_ADDR, 8'h23);
        axw(PHASE_TWO_ADDR, 8'h08);
        axw(AUX_CONTROL_ADDR, 8'h40);
        axw(MAIN_CTRL_ADDR, 8'h01);
        trip1 <= 5'h04; // enabled comparator must be ignored here
        meas(10, 54);
        // every delay class of the dead select field
        for (int i = 0; i < 5; i++) begin
            axw(AUX_CONTROL_ADDR, 8'h40 | 8'(sel[i]));
            meas(2 * (5 - dl[i]), 2 * (27 - dl[i]));
        end
        // overlap: both outputs inverted, drivers crossed on the board,
        // so the dead band of two cycles becomes overlap
        axw(PHASE_ONE_ADDR, 8'ha3);
        axw(PHASE_TWO_ADDR, 8'h88);
        axw(AUX_CONTROL_ADDR, 8'h55);
        meas(58, 14);
        axw(PHASE_ONE_ADDR, 8'h23);
        axw(PHASE_TWO_ADDR, 8'h08);
        // comparator mode, only the enabled comparator ends the interval
        axw(AUX_CONTROL_ADDR, 8'h20);
        trip1 <= 5'h0a;
        trip2 <= 5'h05;
        meas(14, 50);
        axw(PHASE_ONE_ADDR, 8'h43);
        meas(4, 60);
        // combined mode, first of comparator and count match wins
        axw(PHASE_ONE_ADDR, 8'h23);
        axw(AUX_CONTROL_ADDR, 8'h60);
        trip1 <= 5'h06;
        meas(6, 58);
        trip1 <= 5'h14;
        meas(10, 54);
        // shutdown, released mid-period away from the start match
        shutdown <= 1'b1;
        repeat (10) @(posedge clk);
        chk("phaseOneOut in shutdown", 32'h0, p1);
        chk("phaseTwoOut in shutdown", 32'h0, p2);
        while (cnt !== 5'h0a) @(posedge clk);
        shutdown <= 1'b0;
        repeat (6) @(posedge clk);
        chk("phaseOneOut start-up", 32'h0, p1);
        chk("phaseTwoOut start-up", 32'h1, p2);
        axr(STATUS_ADDR);
        chk("status start-up", 32'h0a, rd);
        // normal mode: phase two has its own enable, left off
        axw(AUX_CONTROL_ADDR, 8'h00);
        trip1 <= 5'h0a;
        meas(14, 0);
        // normal mode: phase two on its own count and comparator one
        axw(PHASE_TWO_ADDR, 8'h28);
        axw(MAIN_CTRL_ADDR, 8'h03);
        meas(14, 4);
        final_report;
    end
    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report;
    end
endmodule
